// File: hdl/flash_guard_pkg.sv
// constants, register map and states of the flash program/erase guard
package flash_guard_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] PSC_OFF  = 8'h8f;  // program_store_control
  localparam logic [7:0] TMG_OFF  = 8'hb6;  // flash_timing_register
  localparam logic [7:0] LIM_OFF  = 8'hb7;  // flash_read_limit
  localparam logic [7:0] STAT_OFF = 8'hb8;  // status
  localparam int         WE_BIT   = 0;
  localparam int         EE_BIT   = 1;
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_ERASE_BIT = 1;
  localparam int         ST_LIM_BIT   = 2;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [3:0] TMG_RESET   = 4'hf;
  localparam logic [3:0] PRESCALE_OFF = 4'hf;
  localparam logic [7:0] LIMIT_RESET = 8'h00;

  // -----------------------------------------------------------------
  // flash layout
  // -----------------------------------------------------------------
  localparam int          MEM_DEPTH     = 32896;
  localparam logic [15:0] SCRATCH_BASE  = 16'h8000;
  localparam logic [15:0] SCRATCH_LAST  = 16'h807f;
  localparam logic [15:0] LOCK_WE_ADDR  = 16'h7dfe;
  localparam logic [15:0] LOCK_RD_ADDR  = 16'h7dff;
  localparam logic [15:0] LOCK_PAGE     = 16'h7c00;
  localparam logic [15:0] FULL_FIRST    = 16'h0000;
  localparam logic [15:0] FULL_LAST     = 16'h7dff;
  localparam logic [15:0] SECTOR_SPAN   = 16'h01ff;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  BLOCKED_BYTE  = 8'h00;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_MIN_NS   = 20000;     // one period of 50 kHz
  localparam int WRITE_TIME_NS = 40000;
  localparam int ERASE_TIME_NS = 10000000;
  localparam int WRITE_TICKS_I = (WRITE_TIME_NS + TICK_MIN_NS - 1) / TICK_MIN_NS;
  localparam int ERASE_TICKS_I = (ERASE_TIME_NS + TICK_MIN_NS - 1) / TICK_MIN_NS;
  localparam logic [9:0] WRITE_TICKS = 10'(WRITE_TICKS_I);
  localparam logic [9:0] ERASE_TICKS = 10'(ERASE_TICKS_I);

  // -----------------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INIT_WE = 2'b00,
    ST_INIT_RD = 2'b01,
    ST_IDLE    = 2'b11,
    ST_BUSY    = 2'b10
  } state_t;

endpackage

// File: hdl/flash_array.sv
// byte-wide flash array with program (and-in) and erase writes
`timescale 1ns/1ps
module flash_array (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        re,
  input  wire logic        we,
  input  wire logic        erase,
  input  wire logic        zero,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);

  logic [7:0] mem [flash_guard_pkg::MEM_DEPTH];
  logic [7:0] rdata_q;

  // -----------------------------------------------------------------
  // write port
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= erase ? flash_guard_pkg::ERASED_BYTE : (mem[addr] & wdata);
    end
  end

  // -----------------------------------------------------------------
  // registered read port
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (re) begin
      rdata_q <= zero ? flash_guard_pkg::BLOCKED_BYTE : mem[addr];
    end
  end

  assign rdata = rdata_q;

endmodule

// File: hdl/flash_program_erase_guard.sv
// flash program/erase sequencer with lock bytes and software read limit
// Summary of operation
// - core byte program only while write enable set; debug writes ignore it
// - program clears bits, only erase sets
// - both enables: write erases whole sector
// - erase enable holds until software clears
// - erase enable alone never erases
// - prescale times operations, 1111b disables
// - core stalled while operation runs
// - extra 128-byte sector at 0x8000
// - lock bytes gate debug access per block
// - software cannot erase the lock sector
// - lock bits always readable and clearable
// - debug erase at lock byte: full erase
// - debug erase elsewhere in lock page: page
// - read limit is register value times 256
// - upper code blocked below limit, reads zero
// - lower code and fetches unrestricted
// - read limit written once per reset
// - read limit resets to zero
// - upper control bits read zero
// - written by data writes, read by code reads
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module flash_program_erase_guard #(
  parameter logic [9:0] WRITE_TICKS = flash_guard_pkg::WRITE_TICKS,
  parameter logic [9:0] ERASE_TICKS = flash_guard_pkg::ERASE_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        xwr_valid,
  input  wire logic [15:0] xwr_addr,
  input  wire logic [7:0]  xwr_data,
  input  wire logic        code_rd,
  input  wire logic        code_fetch,
  input  wire logic [15:0] code_addr,
  input  wire logic [15:0] code_pc,
  output logic      [7:0]  code_rdata,
  output logic             core_stall,
  input  wire logic        dbg_rd,
  input  wire logic        dbg_wr,
  input  wire logic        dbg_erase,
  input  wire logic [15:0] dbg_addr,
  input  wire logic [7:0]  dbg_wdata,
  output logic             dbg_ready,
  output logic      [7:0]  dbg_rdata,
  output logic             dbg_rvalid,
  output logic             dbg_denied
);

  flash_guard_pkg::state_t state_q;
  logic [1:0]  ctrl_q;
  logic [3:0]  tmg_q;
  logic [7:0]  limit_q;
  logic        limit_set_q;
  logic [7:0]  lock_we_q;
  logic [7:0]  lock_rd_q;
  logic        init_tail_q;
  logic [14:0] pre_q;
  logic [9:0]  ticks_q;
  logic [9:0]  need_q;
  logic [15:0] walk_q;
  logic [15:0] walk_last_q;
  logic        walk_on_q;
  logic        erasing_q;
  logic [7:0]  reg_rdata_q;
  logic        dbg_rvalid_q;
  logic        dbg_denied_q;
  logic        mem_re;
  logic        mem_we;
  logic        mem_erase;
  logic        mem_zero;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        idle;
  logic        psc_on;
  logic        sw_erase;
  logic        core_go;
  logic        dbg_go_w;
  logic        dbg_go_e;
  logic        op_go;
  logic        op_erase;
  logic [15:0] erase_first;
  logic [15:0] erase_last;
  logic [14:0] psc_mask;
  logic        tick;
  logic        op_done;
  logic        dbg_rd_ok;

  // -----------------------------------------------------------------
  // address helpers
  // -----------------------------------------------------------------
  function automatic logic in_flash(input logic [15:0] a);
    in_flash = a <= flash_guard_pkg::SCRATCH_LAST;
  endfunction

  function automatic logic in_lock_page(input logic [15:0] a);
    in_lock_page = a >= flash_guard_pkg::LOCK_PAGE && a <= flash_guard_pkg::FULL_LAST;
  endfunction

  function automatic logic is_lock_byte(input logic [15:0] a);
    is_lock_byte = a == flash_guard_pkg::LOCK_WE_ADDR || a == flash_guard_pkg::LOCK_RD_ADDR;
  endfunction

  function automatic logic srl_block(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] lim);
    srl_block = pc >= {lim, 8'h00} && a < {lim, 8'h00};
  endfunction

  function automatic logic lock_open(input logic [7:0] lk, input logic [15:0] a);
    lock_open = a[15] || lk[a[14:12]];
  endfunction

  // -----------------------------------------------------------------
  // acceptance of operations
  // -----------------------------------------------------------------
  assign idle      = state_q == flash_guard_pkg::ST_IDLE;
  assign psc_on    = tmg_q != flash_guard_pkg::PRESCALE_OFF;
  assign sw_erase  = ctrl_q[flash_guard_pkg::EE_BIT] && ctrl_q[flash_guard_pkg::WE_BIT];
  assign dbg_ready = idle && !xwr_valid && !code_rd;
  assign dbg_rd_ok = lock_open(lock_rd_q, dbg_addr) || is_lock_byte(dbg_addr);

  always_comb begin
    core_go = xwr_valid && idle && ctrl_q[flash_guard_pkg::WE_BIT] && psc_on && in_flash(xwr_addr);
    if (srl_block(code_pc, xwr_addr, limit_q)) begin
      core_go = 1'b0;
    end
    if (sw_erase && in_lock_page(xwr_addr)) begin
      core_go = 1'b0;
    end
  end

  assign dbg_go_w = dbg_wr && dbg_ready && psc_on && in_flash(dbg_addr)
                    && (lock_open(lock_we_q, dbg_addr) || is_lock_byte(dbg_addr));
  assign dbg_go_e = dbg_erase && dbg_ready && psc_on && in_flash(dbg_addr)
                    && (lock_open(lock_we_q, dbg_addr) || in_lock_page(dbg_addr));
  assign op_go    = core_go || dbg_go_w || dbg_go_e;
  assign op_erase = (core_go && sw_erase) || dbg_go_e;

  always_comb begin
    erase_first = core_go ? {xwr_addr[15:9], 9'h000} : {dbg_addr[15:9], 9'h000};
    erase_last  = erase_first | flash_guard_pkg::SECTOR_SPAN;
    if (erase_first >= flash_guard_pkg::SCRATCH_BASE) begin
      erase_last = flash_guard_pkg::SCRATCH_LAST;
    end
    if (dbg_go_e && !core_go && is_lock_byte(dbg_addr)) begin
      erase_first = flash_guard_pkg::FULL_FIRST;
      erase_last  = flash_guard_pkg::FULL_LAST;
    end else if (dbg_go_e && !core_go && in_lock_page(dbg_addr)) begin
      erase_first = flash_guard_pkg::LOCK_PAGE;
      erase_last  = flash_guard_pkg::FULL_LAST;
    end
  end

  // -----------------------------------------------------------------
  // flash port steering
  // -----------------------------------------------------------------
  always_comb begin
    mem_re    = 1'b0;
    mem_we    = 1'b0;
    mem_erase = 1'b0;
    mem_zero  = 1'b0;
    mem_addr  = code_addr;
    mem_wdata = xwr_data;
    if (state_q == flash_guard_pkg::ST_BUSY) begin
      // only the erase walk sets bits
      mem_we    = walk_on_q;
      mem_erase = 1'b1;
      mem_addr  = walk_q;
    end else if (state_q == flash_guard_pkg::ST_INIT_WE) begin
      mem_re   = 1'b1;
      mem_addr = flash_guard_pkg::LOCK_WE_ADDR;
    end else if (state_q == flash_guard_pkg::ST_INIT_RD) begin
      mem_re   = 1'b1;
      mem_addr = flash_guard_pkg::LOCK_RD_ADDR;
    end else if (core_go) begin
      mem_we   = !sw_erase;
      mem_addr = xwr_addr;
    end else if (dbg_go_w) begin
      mem_we    = 1'b1;
      mem_addr  = dbg_addr;
      mem_wdata = dbg_wdata;
    end else if (code_rd) begin
      mem_re   = 1'b1;
      mem_zero = !in_flash(code_addr) || (!code_fetch && srl_block(code_pc, code_addr, limit_q));
    end else if (dbg_rd && dbg_ready) begin
      mem_re   = 1'b1;
      mem_addr = dbg_addr;
      mem_zero = !in_flash(dbg_addr) || !dbg_rd_ok;
    end
  end

  flash_array u_array (
    .clk_sys (clk_sys),
    .rst     (rst),
    .re      (mem_re),
    .we      (mem_we),
    .erase   (mem_erase),
    .zero    (mem_zero),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  // tick counts cover 40us and 10ms
  assign psc_mask = 15'((16'h0001 << tmg_q) - 16'h0001);
  assign tick     = pre_q == psc_mask;
  assign op_done  = !walk_on_q && ticks_q >= need_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= flash_guard_pkg::ST_INIT_WE;
    end else begin
      unique case (state_q)
        flash_guard_pkg::ST_INIT_WE: state_q <= flash_guard_pkg::ST_INIT_RD;
        flash_guard_pkg::ST_INIT_RD: state_q <= flash_guard_pkg::ST_IDLE;
        flash_guard_pkg::ST_IDLE: begin
          if (op_go) begin
            state_q <= flash_guard_pkg::ST_BUSY;
          end
        end
        flash_guard_pkg::ST_BUSY: begin
          if (op_done) begin
            state_q <= flash_guard_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || state_q != flash_guard_pkg::ST_BUSY) begin
      pre_q   <= 15'h0000;
      ticks_q <= 10'h000;
    end else begin
      pre_q <= tick ? 15'h0000 : pre_q + 15'h0001;
      if (tick && ticks_q != 10'h3ff) begin
        ticks_q <= ticks_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      walk_q      <= 16'h0000;
      walk_last_q <= 16'h0000;
      walk_on_q   <= 1'b0;
      erasing_q   <= 1'b0;
      need_q      <= 10'h000;
    end else if (idle && op_go) begin
      walk_q      <= erase_first;
      walk_last_q <= erase_last;
      walk_on_q   <= op_erase;
      erasing_q   <= op_erase;
      need_q      <= op_erase ? ERASE_TICKS : WRITE_TICKS;
    end else if (walk_on_q) begin
      walk_q    <= walk_q + 16'h0001;
      walk_on_q <= walk_q != walk_last_q;
    end else if (op_done) begin
      erasing_q <= 1'b0;
    end
  end

  assign core_stall = state_q != flash_guard_pkg::ST_IDLE;

  // -----------------------------------------------------------------
  // lock byte shadows
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      init_tail_q <= 1'b0;
      lock_we_q   <= 8'h00;
      lock_rd_q   <= 8'h00;
    end else begin
      init_tail_q <= state_q == flash_guard_pkg::ST_INIT_RD;
      if (state_q == flash_guard_pkg::ST_INIT_RD) begin
        lock_we_q <= mem_rdata;
      end else if (mem_we && mem_addr == flash_guard_pkg::LOCK_WE_ADDR) begin
        lock_we_q <= mem_erase ? flash_guard_pkg::ERASED_BYTE : lock_we_q & mem_wdata;
      end
      if (init_tail_q) begin
        lock_rd_q <= mem_rdata;
      end else if (mem_we && mem_addr == flash_guard_pkg::LOCK_RD_ADDR) begin
        lock_rd_q <= mem_erase ? flash_guard_pkg::ERASED_BYTE : lock_rd_q & mem_wdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= flash_guard_pkg::CTRL_RESET;
      tmg_q  <= flash_guard_pkg::TMG_RESET;
    end else if (reg_wr && reg_addr == flash_guard_pkg::PSC_OFF) begin
      ctrl_q <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == flash_guard_pkg::TMG_OFF) begin
      tmg_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      limit_q     <= flash_guard_pkg::LIMIT_RESET;
      limit_set_q <= 1'b0;
    end else if (reg_wr && reg_addr == flash_guard_pkg::LIM_OFF && !limit_set_q) begin
      limit_q     <= reg_wdata;
      limit_set_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        flash_guard_pkg::PSC_OFF:  reg_rdata_q <= {6'h00, ctrl_q};
        flash_guard_pkg::TMG_OFF:  reg_rdata_q <= {4'h0, tmg_q};
        flash_guard_pkg::LIM_OFF:  reg_rdata_q <= limit_q;
        flash_guard_pkg::STAT_OFF: reg_rdata_q <= {5'h00, limit_set_q, erasing_q, !idle};
        default:                   reg_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbg_rvalid_q <= 1'b0;
      dbg_denied_q <= 1'b0;
    end else begin
      dbg_rvalid_q <= dbg_rd && dbg_ready;
      dbg_denied_q <= dbg_ready && ((dbg_rd && !dbg_rd_ok) || (dbg_wr && !dbg_go_w)
                      || (dbg_erase && !dbg_go_e));
    end
  end

  assign reg_rdata  = reg_rdata_q;
  assign code_rdata = mem_rdata;
  assign dbg_rdata  = mem_rdata;
  assign dbg_rvalid = dbg_rvalid_q;
  assign dbg_denied = dbg_denied_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  prog_needs_we_a: assert property (core_go |-> ctrl_q[0]) else $error("program without write enable");
  set_only_erase_a: assert property (mem_we && mem_erase |-> state_q == flash_guard_pkg::ST_BUSY)
    else $error("bits set outside erase");
  erase_walk_a: assert property (idle && core_go && sw_erase && !xwr_addr[15] |=> walk_on_q [*8])
    else $error("sector erase too short");
  erase_both_a: assert property (idle && op_go && !ctrl_q[0] && !dbg_erase |=> !erasing_q)
    else $error("erase without write enable");
  prescale_off_a: assert property (tmg_q == 4'hf |-> !op_go) else $error("operation while disabled");
  stall_busy_a: assert property (idle && op_go |=> core_stall [*2]) else $error("core not stalled");
  lock_sector_a: assert property (core_go && sw_erase |-> !in_lock_page(xwr_addr))
    else $error("lock sector erased");
  srl_zero_a: assert property (idle && code_rd && !code_fetch && srl_block(code_pc, code_addr, limit_q)
    |=> code_rdata == 8'h00) else $error("blocked read not zero");
  limit_once_a: assert property (limit_set_q |=> $stable(limit_q)) else $error("limit rewritten");
  ctrl_upper_a: assert property (reg_rd && reg_addr == 8'h8f |=> reg_rdata[7:2] == 6'h00)
    else $error("upper control bits set");

  erase_seen_c: cover property (idle && core_go && sw_erase);
  prog_seen_c: cover property (idle && core_go && !sw_erase);
  full_erase_c: cover property (dbg_go_e && is_lock_byte(dbg_addr));
  srl_hit_c: cover property (code_rd && !code_fetch && srl_block(code_pc, code_addr, limit_q));

endmodule

// File: dv/core_model.sv
// processor core model: external-data writes and code reads
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk_sys,
  input  wire logic        core_stall,
  input  wire logic [7:0]  code_rdata,
  output logic             xwr_valid,
  output logic      [15:0] xwr_addr,
  output logic      [7:0]  xwr_data,
  output logic             code_rd,
  output logic             code_fetch,
  output logic      [15:0] code_addr,
  output logic      [15:0] code_pc
);
  initial begin
    xwr_valid  = 1'b0;
    xwr_addr   = 16'h0000;
    xwr_data   = 8'h00;
    code_rd    = 1'b0;
    code_fetch = 1'b0;
    code_addr  = 16'h0000;
    code_pc    = 16'h0000;
  end

  task automatic xwrite(input logic [15:0] pc, a, input logic [7:0] d, output int n);
    n = 0;
    @(posedge clk_sys);
    xwr_valid <= 1'b1;
    xwr_addr  <= a;
    xwr_data  <= d;
    code_pc   <= pc;
    @(posedge clk_sys);
    xwr_valid <= 1'b0;
    xwr_addr  <= ~a;
    xwr_data  <= ~d;
    #1;
    while (core_stall === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic cread(input logic [15:0] pc, a, input logic f, output logic [7:0] v);
    @(posedge clk_sys);
    code_rd    <= 1'b1;
    code_pc    <= pc;
    code_addr  <= a;
    code_fetch <= f;
    @(posedge clk_sys);
    code_rd    <= 1'b0;
    code_addr  <= ~a;
    #1;
    v = code_rdata;
  endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the flash program/erase guard
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("BAD %0t %0h %0h", $time, g, e); end end
module tb_top;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        xwr_valid;
  logic [15:0] xwr_addr;
  logic [7:0]  xwr_data;
  logic        code_rd;
  logic        code_fetch;
  logic [15:0] code_addr;
  logic [15:0] code_pc;
  logic [7:0]  code_rdata;
  logic        core_stall;
  logic        dbg_rd;
  logic        dbg_wr;
  logic        dbg_erase;
  logic [15:0] dbg_addr;
  logic [7:0]  dbg_wdata;
  logic [7:0]  dbg_rdata;
  logic        dbg_rvalid;
  logic        dbg_denied;
  logic [15:0] ra;
  logic [7:0]  rd;
  logic [7:0]  mem [int];
  int          errors;
  int          num_checks;
  int          cyc;
  int          seed;

  flash_program_erase_guard #(.WRITE_TICKS(10'h002), .ERASE_TICKS(10'h004)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xwr_valid(xwr_valid), .xwr_addr(xwr_addr),
    .xwr_data(xwr_data), .code_rd(code_rd), .code_fetch(code_fetch), .code_addr(code_addr),
    .code_pc(code_pc), .code_rdata(code_rdata), .core_stall(core_stall), .dbg_rd(dbg_rd),
    .dbg_wr(dbg_wr), .dbg_erase(dbg_erase), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_ready(),
    .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid), .dbg_denied(dbg_denied));

  core_model i_core (
    .clk_sys(clk_sys), .core_stall(core_stall), .code_rdata(code_rdata), .xwr_valid(xwr_valid),
    .xwr_addr(xwr_addr), .xwr_data(xwr_data), .code_rd(code_rd), .code_fetch(code_fetch),
    .code_addr(code_addr), .code_pc(code_pc));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 45000) begin
      errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic do_reset(input int n);
    int k;
    k = 0;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    while (core_stall !== 1'b0 && k < 10) begin
      k++;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic rw(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rr(input logic [7:0] a, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic fw(input logic [15:0] pc, a, input logic [7:0] d, input int kind, lo);
    int n;
    int b;
    i_core.xwrite(pc, a, d, n);
    `CHK(kind == 0 ? n == 0 : n >= lo, 1'b1)
    if (kind == 1) begin
      mem[a] = mem[a] & d;
    end
    if (kind == 2) begin
      b = a >= 16'h8000 ? 128 : 512;
      for (int i = 0; i < b; i++) begin
        mem[(a & ~(b - 1)) + i] = 8'hff;
      end
    end
  endtask

  task automatic cr(input logic [15:0] pc, a, input logic f, input logic [7:0] e);
    logic [7:0] v;
    i_core.cread(pc, a, f, v);
    `CHK(v, e)
  endtask

  task automatic dbg(input int k, input logic [15:0] a, input logic [7:0] d, e, input logic den);
    int n;
    n = 0;
    @(posedge clk_sys);
    dbg_rd    <= k == 0;
    dbg_wr    <= k == 1;
    dbg_erase <= k == 2;
    dbg_addr  <= a;
    dbg_wdata <= d;
    @(posedge clk_sys);
    dbg_rd    <= 1'b0;
    dbg_wr    <= 1'b0;
    dbg_erase <= 1'b0;
    #1;
    `CHK(dbg_denied, den)
    `CHK(dbg_rvalid, k == 0)
    if (k == 0) begin
      `CHK(dbg_rdata, e)
    end
    while (core_stall === 1'b1 && n < 40000) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 88414;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dbg_rd = 1'b0;
    dbg_wr = 1'b0;
    dbg_erase = 1'b0;
    dbg_addr = 16'h0000;
    dbg_wdata = 8'h00;
    do_reset(20);
    rr(flash_guard_pkg::PSC_OFF, 8'h00);
    rr(flash_guard_pkg::LIM_OFF, 8'h00);
    rr(8'h55, 8'h00);
    rw(flash_guard_pkg::PSC_OFF, 8'hff);
    rr(flash_guard_pkg::PSC_OFF, 8'h03);
    fw(16'h0100, 16'h0010, 8'h00, 0, 0);
    rw(flash_guard_pkg::TMG_OFF, 8'hf0);
    rr(flash_guard_pkg::TMG_OFF, 8'h00);
    $display("registers done");
    fw(16'h0100, 16'h0123, 8'h5a, 2, 512);
    fw(16'h0100, 16'h03ab, 8'h00, 2, 512);
    cr(16'h0100, 16'h0000, 1'b0, 8'hff);
    rw(flash_guard_pkg::PSC_OFF, 8'h01);
    fw(16'h0100, 16'h01ff, 8'h12, 1, 2);
    fw(16'h0100, 16'h0200, 8'h34, 1, 2);
    rw(flash_guard_pkg::PSC_OFF, 8'h03);
    fw(16'h0100, 16'h0201, 8'h77, 2, 512);
    cr(16'h0100, 16'h01ff, 1'b0, mem[16'h01ff]);
    cr(16'h0100, 16'h0200, 1'b0, mem[16'h0200]);
    rw(flash_guard_pkg::PSC_OFF, 8'h01);
    fw(16'h0100, 16'h0010, 8'h5a, 1, 2);
    fw(16'h0100, 16'h0010, 8'hf0, 1, 2);
    cr(16'h0100, 16'h0010, 1'b0, 8'h50);
    rw(flash_guard_pkg::PSC_OFF, 8'h02);
    fw(16'h0100, 16'h0010, 8'h00, 0, 0);
    rw(flash_guard_pkg::PSC_OFF, 8'h00);
    fw(16'h0100, 16'h0010, 8'h00, 0, 0);
    cr(16'h0100, 16'h0010, 1'b0, 8'h50);
    $display("program and erase done");
    rw(flash_guard_pkg::PSC_OFF, 8'h01);
    rw(flash_guard_pkg::TMG_OFF, 8'h01);
    fw(16'h0100, 16'h0011, 8'h0f, 1, 4);
    rw(flash_guard_pkg::TMG_OFF, 8'h00);
    rw(flash_guard_pkg::PSC_OFF, 8'h03);
    fw(16'h0100, 16'h8040, 8'h00, 2, 128);
    fw(16'h0100, 16'h7c10, 8'h00, 0, 0);
    rw(flash_guard_pkg::PSC_OFF, 8'h01);
    fw(16'h0100, 16'h807f, 8'ha5, 1, 2);
    cr(16'h0100, 16'h8000, 1'b0, 8'hff);
    cr(16'h0100, 16'h807f, 1'b0, 8'ha5);
    cr(16'h0100, 16'h8080, 1'b0, 8'h00);
    for (int i = 0; i < 10; i++) begin
      ra = 16'h0100 | (16'($random(seed)) & 16'h00fe);
      rd = 8'($random(seed));
      fw(16'h0100, ra, rd, 1, 2);
      cr(16'h0100, ra, 1'b0, mem[ra]);
    end
    $display("scratch and random done");
    fw(16'h0100, 16'h0020, 8'ha5, 1, 2);
    rw(flash_guard_pkg::LIM_OFF, 8'h02);
    rw(flash_guard_pkg::LIM_OFF, 8'h05);
    rr(flash_guard_pkg::LIM_OFF, 8'h02);
    rr(flash_guard_pkg::STAT_OFF, 8'h04);
    cr(16'h0300, 16'h0020, 1'b0, 8'h00);
    cr(16'h0200, 16'h01ff, 1'b0, 8'h00);
    cr(16'h0300, 16'h0020, 1'b1, 8'ha5);
    cr(16'h01ff, 16'h0020, 1'b0, 8'ha5);
    cr(16'h0300, 16'h0200, 1'b0, mem[16'h0200]);
    fw(16'h0300, 16'h0020, 8'h00, 0, 0);
    cr(16'h0100, 16'h0020, 1'b0, 8'ha5);
    do_reset(3);
    rr(flash_guard_pkg::LIM_OFF, 8'h00);
    rr(flash_guard_pkg::PSC_OFF, 8'h00);
    rw(flash_guard_pkg::LIM_OFF, 8'h07);
    rr(flash_guard_pkg::LIM_OFF, 8'h07);
    cr(16'h0800, 16'h0020, 1'b0, 8'h00);
    cr(16'h0600, 16'h0020, 1'b0, 8'ha5);
    $display("read limit done");
    dbg(2, 16'h7c00, 8'h00, 8'h00, 1'b1);
    rw(flash_guard_pkg::TMG_OFF, 8'h00);
    dbg(2, 16'h7c00, 8'h00, 8'h00, 1'b0);
    dbg(0, 16'h7dfe, 8'h00, 8'hff, 1'b0);
    dbg(1, 16'h7dfe, 8'hfe, 8'h00, 1'b0);
    dbg(0, 16'h7dfe, 8'h00, 8'hfe, 1'b0);
    dbg(1, 16'h0030, 8'h00, 8'h00, 1'b1);
    dbg(2, 16'h0000, 8'h00, 8'h00, 1'b1);
    dbg(0, 16'h0020, 8'h00, mem[16'h0020], 1'b0);
    dbg(1, 16'h7dff, 8'hfe, 8'h00, 1'b0);
    dbg(0, 16'h0020, 8'h00, 8'h00, 1'b1);
    dbg(2, 16'h7dff, 8'h00, 8'h00, 1'b0);
    dbg(0, 16'h0020, 8'h00, 8'hff, 1'b0);
    $display("debug port done");
    finish_test();
  end
endmodule
